/* File: dsram_pkg.sv */
package dsram_pkg;

  // ************************************************************
  // variant widths
  // ************************************************************
  // built as the 18-bit variant; the other two kept for reference
  localparam int X8_ADDR_W   = 21;
  localparam int X8_DATA_W   = 8;
  localparam int X8_LANES    = 2;
  localparam int X36_ADDR_W  = 19;
  localparam int X36_DATA_W  = 36;
  localparam int X36_LANES   = 4;
  localparam int ADDR_W      = 20;
  localparam int DATA_W      = 18;
  localparam int LANES       = 2;
  localparam int LANE_W      = 9;
  localparam int WORD_AW     = ADDR_W + 1;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CORE_MHZ        = 250;
  localparam int STOP_DETECT_NS  = 40;
  localparam int STOP_DETECT_CYC = STOP_DETECT_NS * CORE_MHZ / 1000;
  localparam int IDLE_W          = 4;
  localparam logic [IDLE_W-1:0] STOP_DETECT_CNT = IDLE_W'(STOP_DETECT_CYC);
  localparam int RESTART_STROBES = 1024;
  localparam int CNT_W           = 11;
  localparam logic [CNT_W-1:0] RESTART_CNT = CNT_W'(RESTART_STROBES);
  localparam int ZQ_PERIOD_STROBES = 256;
  localparam int ZQ_W              = 8;
  localparam logic [ZQ_W-1:0] ZQ_PERIOD_CNT = ZQ_W'(ZQ_PERIOD_STROBES - 1);

  // ************************************************************
  // impedance
  // ************************************************************
  localparam int RQ_W      = 10;
  localparam int IMP_W     = 8;
  localparam int RQ_RATIO  = 5;
  localparam logic [IMP_W-1:0] IMP_POWERUP_OHM = 8'h32;

endpackage

/* File: dsram_if.sv */
`timescale 1ns/1ps
interface dsram_if;
  logic                                 strobe_true;
  logic                                 strobe_inv;
  logic                                 out_ref_true;
  logic                                 out_ref_inv;
  logic [dsram_pkg::ADDR_W-1:0]         addr;
  logic                                 read_sel;
  logic                                 bank_select_n;
  logic [dsram_pkg::DATA_W-1:0]         wdata;
  logic [dsram_pkg::LANES-1:0]          byte_lane_mask_n;
  logic [dsram_pkg::DATA_W-1:0]         rdata;
  logic                                 rdata_oe_n;
  logic                                 echo_strobe_true;
  logic                                 echo_strobe_inv;

  modport dev (
    input  strobe_true, strobe_inv, out_ref_true, out_ref_inv, addr, read_sel,
    input  bank_select_n, wdata, byte_lane_mask_n,
    output rdata, rdata_oe_n, echo_strobe_true, echo_strobe_inv
  );

  modport host (
    output strobe_true, strobe_inv, out_ref_true, out_ref_inv, addr, read_sel,
    output bank_select_n, wdata, byte_lane_mask_n,
    input  rdata, rdata_oe_n, echo_strobe_true, echo_strobe_inv
  );
endinterface

/* File: dsram_ctl.sv */
`timescale 1ns/1ps
module dsram_ctl (
  input  wire logic                         i_core_clk,
  input  wire logic                         i_reset_n,
  input  wire logic                         i_strobe_stop,
  input  wire logic                         i_single_strobe,
  input  wire logic                         i_req_valid,
  input  wire logic                         i_req_write,
  input  wire logic [dsram_pkg::ADDR_W-1:0] i_req_addr,
  input  wire logic [dsram_pkg::DATA_W-1:0] i_req_wdata0,
  input  wire logic [dsram_pkg::DATA_W-1:0] i_req_wdata1,
  input  wire logic [dsram_pkg::LANES-1:0]  i_req_mask0_n,
  input  wire logic [dsram_pkg::LANES-1:0]  i_req_mask1_n,
  output logic                              o_req_ready,
  output logic                              o_link_ready,
  output logic                              o_rd_valid,
  output logic [dsram_pkg::DATA_W-1:0]      o_rd_data0,
  output logic [dsram_pkg::DATA_W-1:0]      o_rd_data1,
  dsram_if.host                             bus
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic                             k;
    logic                             kn;
    logic                             c;
    logic                             cn;
    logic                             ready;
    logic                             bank_n;
    logic                             read_sel;
    logic [dsram_pkg::ADDR_W-1:0]     addr;
    logic [dsram_pkg::DATA_W-1:0]     wdata;
    logic [dsram_pkg::LANES-1:0]      mask_n;
    logic                             wq_v;
    logic [dsram_pkg::DATA_W-1:0]     wq_d0;
    logic [dsram_pkg::DATA_W-1:0]     wq_d1;
    logic [dsram_pkg::LANES-1:0]      wq_m0;
    logic [dsram_pkg::LANES-1:0]      wq_m1;
    logic                             wp_v;
    logic [dsram_pkg::DATA_W-1:0]     wp_d1;
    logic [dsram_pkg::LANES-1:0]      wp_m1;
    logic                             stp;
    logic [dsram_pkg::CNT_W-1:0]      run_cnt;
    logic                             link_ready;
    logic                             et_prev;
    logic                             ei_prev;
    logic                             rd0_v;
    logic [dsram_pkg::DATA_W-1:0]     rd0;
    logic                             rd_valid;
    logic [dsram_pkg::DATA_W-1:0]     rd_d0;
    logic [dsram_pkg::DATA_W-1:0]     rd_d1;
  } dsram_ctl_state_t;

  localparam dsram_ctl_state_t CTL_RST = '{kn: 1'b1, cn: 1'b1, bank_n: 1'b1, et_prev: 1'b1,
                                           mask_n: '1, default: '0};

  dsram_ctl_state_t state_reg;
  dsram_ctl_state_t state_next;
  logic             take;

  assign take = i_req_valid & state_reg.ready;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    state_next          = state_reg;
    state_next.rd_valid = 1'b0;
    if (state_reg.k)
    begin
      // inverted strobe rises: second write word goes out
      state_next.k      = 1'b0;
      state_next.kn     = 1'b1;
      state_next.stp    = i_strobe_stop;
      state_next.wdata  = state_reg.wp_d1;
      state_next.mask_n = state_reg.wp_v ? state_reg.wp_m1 : '1;
      state_next.wp_v   = 1'b0;
      state_next.ready  = ~i_strobe_stop & state_reg.link_ready;
    end
    else if (!(state_reg.stp && i_strobe_stop))
    begin
      // true strobe rises: command and first write word
      state_next.k        = 1'b1;
      state_next.kn       = 1'b0;
      state_next.stp      = 1'b0;
      state_next.ready    = 1'b0;
      state_next.bank_n   = ~take;
      state_next.read_sel = ~i_req_write;
      state_next.addr     = i_req_addr;
      state_next.wdata    = state_reg.wq_d0;
      state_next.mask_n   = state_reg.wq_v ? state_reg.wq_m0 : '1;
      state_next.wp_v     = state_reg.wq_v;
      state_next.wp_d1    = state_reg.wq_d1;
      state_next.wp_m1    = state_reg.wq_m1;
      state_next.wq_v     = take & i_req_write;
      state_next.wq_d0    = i_req_wdata0;
      state_next.wq_d1    = i_req_wdata1;
      state_next.wq_m0    = i_req_mask0_n;
      state_next.wq_m1    = i_req_mask1_n;
      // no requests until the restart wait has run out
      if (state_reg.run_cnt != dsram_pkg::RESTART_CNT)
      begin
        state_next.run_cnt = state_reg.run_cnt + 1'b1;
      end
      state_next.link_ready = state_reg.link_ready |
                              (state_reg.run_cnt == dsram_pkg::RESTART_CNT - 1'b1);
    end
    else
    begin
      // strobes held: restart wait begins again
      state_next.run_cnt    = '0;
      state_next.link_ready = 1'b0;
      state_next.bank_n     = 1'b1;
    end
    // tied high for single-strobe mode, never toggled then
    state_next.c  = i_single_strobe | state_next.k;
    state_next.cn = i_single_strobe | state_next.kn;

    // read capture on the echo pair
    state_next.et_prev = bus.echo_strobe_true;
    state_next.ei_prev = bus.echo_strobe_inv;
    if (bus.echo_strobe_inv && !state_reg.ei_prev && !bus.rdata_oe_n)
    begin
      state_next.rd0   = bus.rdata;
      state_next.rd0_v = 1'b1;
    end
    if (bus.echo_strobe_true && !state_reg.et_prev)
    begin
      state_next.rd0_v = 1'b0;
      if (state_reg.rd0_v && !bus.rdata_oe_n)
      begin
        state_next.rd_valid = 1'b1;
        state_next.rd_d0    = state_reg.rd0;
        state_next.rd_d1    = bus.rdata;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      state_reg <= CTL_RST;
    else
      state_reg <= state_next;
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign bus.strobe_true      = state_reg.k;
  assign bus.strobe_inv       = state_reg.kn;
  assign bus.out_ref_true     = state_reg.c;
  assign bus.out_ref_inv      = state_reg.cn;
  assign bus.addr             = state_reg.addr;
  assign bus.read_sel         = state_reg.read_sel;
  assign bus.bank_select_n    = state_reg.bank_n;
  assign bus.wdata            = state_reg.wdata;
  assign bus.byte_lane_mask_n = state_reg.mask_n;
  assign o_req_ready          = state_reg.ready;
  assign o_link_ready         = state_reg.link_ready;
  assign o_rd_valid           = state_reg.rd_valid;
  assign o_rd_data0           = state_reg.rd_d0;
  assign o_rd_data1           = state_reg.rd_d1;

endmodule

/* File: dsram_dev.sv */
`timescale 1ns/1ps
// Function
// - address taken at true strobe rise
// - two words per location, lower first
// - bank select sampled at true strobe rise
// - write word and masks each strobe rise
// - read words launched on output reference rises
// - uninterruptible two-word burst, one strobe cycle
// - any request each cycle, no turnaround
// - read high, words after next inverted rise
// - single-strobe references held high, never toggled
// - read outputs released when not delivering
// - write low, data from next true rise
// - reads see pending write register data
// - high lane masks block masked lanes
// - widths per variant; 18-bit built
// - low mask bits 0-8, upper 9-17
// - default impedance until 1024 strobe cycles
// - periodic recalibration never disturbs transfers
// - controller waits 1024 cycles after stop
// - delay loop reset when strobe stops
// - tied references: outputs timed from strobes
// - echo pair follows output reference rises
// - inverted echo rise marks first word
module dsram_dev (
  input  wire logic                         i_core_clk,
  input  wire logic                         i_reset_n,
  input  wire logic [dsram_pkg::RQ_W-1:0]   i_impedance_resistor,
  output logic                              o_dll_locked,
  output logic                              o_impedance_cal_done,
  output logic [dsram_pkg::IMP_W-1:0]       o_drive_impedance,
  dsram_if.dev                              bus
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic                             k_prev;
    logic                             kn_prev;
    logic                             c_prev;
    logic                             cn_prev;
    logic                             rd_cmd_v;
    logic [dsram_pkg::ADDR_W-1:0]     rd_cmd_addr;
    logic                             rd_arm_v;
    logic [dsram_pkg::ADDR_W-1:0]     rd_arm_addr;
    logic                             rd_w1_v;
    logic [dsram_pkg::ADDR_W-1:0]     rd_w1_addr;
    logic                             wr_cmd_v;
    logic [dsram_pkg::ADDR_W-1:0]     wr_cmd_addr;
    logic                             wr_w1_v;
    logic [dsram_pkg::ADDR_W-1:0]     wr_w1_addr;
    logic                             wreg_v;
    logic [dsram_pkg::WORD_AW-1:0]    wreg_addr;
    logic [dsram_pkg::DATA_W-1:0]     wreg_data;
    logic [dsram_pkg::LANES-1:0]      wreg_mask_n;
    logic [dsram_pkg::DATA_W-1:0]     q;
    logic                             q_oe_n;
    logic                             echo_t;
    logic                             echo_i;
    logic [dsram_pkg::IDLE_W-1:0]     idle_cnt;
    logic [dsram_pkg::CNT_W-1:0]      lock_cnt;
    logic                             locked;
    logic [dsram_pkg::CNT_W-1:0]      cal_cnt;
    logic                             cal_done;
    logic [dsram_pkg::ZQ_W-1:0]       zq_cnt;
    logic                             zq_due;
    logic [dsram_pkg::IMP_W-1:0]      drive_imp;
  } dsram_dev_state_t;

  localparam dsram_dev_state_t DEV_RST = '{kn_prev: 1'b1, cn_prev: 1'b1, q_oe_n: 1'b1,
                                           echo_t: 1'b1, drive_imp: dsram_pkg::IMP_POWERUP_OHM,
                                           default: '0};

  dsram_dev_state_t                 state_reg;
  dsram_dev_state_t                 state_next;
  logic [dsram_pkg::DATA_W-1:0]     mem [0:(1 << dsram_pkg::WORD_AW)-1];
  logic                             single;
  logic                             c_eff;
  logic                             cn_eff;
  logic                             k_rise;
  logic                             kn_rise;
  logic                             c_rise;
  logic                             cn_rise;
  logic [dsram_pkg::WORD_AW-1:0]    lk_addr;
  logic [dsram_pkg::DATA_W-1:0]     mem_q;
  logic [dsram_pkg::DATA_W-1:0]     lk_data;

  // ************************************************************
  // strobe edges
  // ************************************************************
  // both references high can only mean they are tied off
  assign single  = bus.out_ref_true & bus.out_ref_inv;
  assign c_eff   = single ? bus.strobe_true : bus.out_ref_true;
  assign cn_eff  = single ? bus.strobe_inv : bus.out_ref_inv;
  assign k_rise  = bus.strobe_true & ~state_reg.k_prev;
  assign kn_rise = bus.strobe_inv & ~state_reg.kn_prev;
  assign c_rise  = c_eff & ~state_reg.c_prev;
  assign cn_rise = cn_eff & ~state_reg.cn_prev;

  // ************************************************************
  // read lookup with write forwarding
  // ************************************************************
  // first word on the inverted reference, second on the true one
  assign lk_addr = cn_rise ? {state_reg.rd_arm_addr, 1'b0}
                           : {state_reg.rd_w1_addr, 1'b1};
  assign mem_q   = mem[lk_addr];

  // lane l covers bits l*9 .. l*9+8
  for (genvar l = 0; l < dsram_pkg::LANES; l++)
  begin : g_fwd
    assign lk_data[l*dsram_pkg::LANE_W +: dsram_pkg::LANE_W] =
      (state_reg.wreg_v && state_reg.wreg_addr == lk_addr && !state_reg.wreg_mask_n[l])
        ? state_reg.wreg_data[l*dsram_pkg::LANE_W +: dsram_pkg::LANE_W]
        : mem_q[l*dsram_pkg::LANE_W +: dsram_pkg::LANE_W];
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    state_next         = state_reg;
    state_next.k_prev  = bus.strobe_true;
    state_next.kn_prev = bus.strobe_inv;
    state_next.c_prev  = c_eff;
    state_next.cn_prev = cn_eff;
    state_next.wreg_v  = 1'b0;

    // output launch; a slot with nothing to send releases the bus
    if (cn_rise)
    begin
      state_next.echo_t = 1'b0;
      state_next.echo_i = 1'b1;
      state_next.q_oe_n = ~state_reg.rd_arm_v;
      if (state_reg.rd_arm_v)
      begin
        state_next.q          = lk_data;
        state_next.rd_w1_v    = 1'b1;
        state_next.rd_w1_addr = state_reg.rd_arm_addr;
        state_next.rd_arm_v   = 1'b0;
      end
    end
    if (c_rise)
    begin
      state_next.echo_t  = 1'b1;
      state_next.echo_i  = 1'b0;
      state_next.q_oe_n  = ~state_reg.rd_w1_v;
      state_next.rd_w1_v = 1'b0;
      if (state_reg.rd_w1_v)
      begin
        state_next.q = lk_data;
      end
    end

    // true strobe rise: command slot and first write word
    if (k_rise)
    begin
      if (state_reg.wr_cmd_v)
      begin
        state_next.wreg_v      = 1'b1;
        state_next.wreg_addr   = {state_reg.wr_cmd_addr, 1'b0};
        state_next.wreg_data   = bus.wdata;
        state_next.wreg_mask_n = bus.byte_lane_mask_n;
        state_next.wr_w1_v     = 1'b1;
        state_next.wr_w1_addr  = state_reg.wr_cmd_addr;
      end
      // a fresh request is taken every cycle whatever came before
      state_next.rd_cmd_v    = ~bus.bank_select_n & bus.read_sel;
      state_next.wr_cmd_v    = ~bus.bank_select_n & ~bus.read_sel;
      state_next.rd_cmd_addr = bus.addr;
      state_next.wr_cmd_addr = bus.addr;
    end

    // inverted strobe rise: second write word, read armed
    if (kn_rise)
    begin
      if (state_reg.wr_w1_v)
      begin
        state_next.wreg_v      = 1'b1;
        state_next.wreg_addr   = {state_reg.wr_w1_addr, 1'b1};
        state_next.wreg_data   = bus.wdata;
        state_next.wreg_mask_n = bus.byte_lane_mask_n;
        state_next.wr_w1_v     = 1'b0;
      end
      state_next.rd_arm_v    = state_reg.rd_cmd_v;
      state_next.rd_arm_addr = state_reg.rd_cmd_addr;
      state_next.rd_cmd_v    = 1'b0;
    end

    // delay loop: stopped strobe forces relock
    if (k_rise)
    begin
      state_next.idle_cnt = '0;
      if (state_reg.lock_cnt != dsram_pkg::RESTART_CNT)
      begin
        state_next.lock_cnt = state_reg.lock_cnt + 1'b1;
      end
      state_next.locked = state_reg.locked |
                          (state_reg.lock_cnt == dsram_pkg::RESTART_CNT - 1'b1);
    end
    else if (state_reg.idle_cnt != dsram_pkg::STOP_DETECT_CNT)
    begin
      state_next.idle_cnt = state_reg.idle_cnt + 1'b1;
    end
    else
    begin
      state_next.lock_cnt = '0;
      state_next.locked   = 1'b0;
    end

    // impedance: power-up value until the first calibration
    if (state_next.zq_due && state_next.q_oe_n && state_reg.q_oe_n)
    begin
      // only applied while the read port is idle, so no edge moves
      state_next.drive_imp = dsram_pkg::IMP_W'(i_impedance_resistor
                                               / dsram_pkg::RQ_RATIO);
      state_next.zq_due    = 1'b0;
    end
    if (k_rise)
    begin
      if (!state_reg.cal_done)
      begin
        state_next.cal_cnt = state_reg.cal_cnt + 1'b1;
        if (state_reg.cal_cnt == dsram_pkg::RESTART_CNT - 1'b1)
        begin
          state_next.cal_done = 1'b1;
          state_next.zq_due   = 1'b1;
        end
      end
      else
      begin
        state_next.zq_cnt = state_reg.zq_cnt + 1'b1;
        if (state_reg.zq_cnt == dsram_pkg::ZQ_PERIOD_CNT)
        begin
          state_next.zq_due = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      state_reg <= DEV_RST;
    else
      state_reg <= state_next;
  end

  // ************************************************************
  // array commit from the write register
  // ************************************************************
  // one clock behind capture; forwarding covers that clock
  always_ff @(posedge i_core_clk)
  begin
    if (state_reg.wreg_v)
    begin
      for (int l = 0; l < dsram_pkg::LANES; l++)
      begin
        if (!state_reg.wreg_mask_n[l])
          mem[state_reg.wreg_addr][l*dsram_pkg::LANE_W +: dsram_pkg::LANE_W] <=
            state_reg.wreg_data[l*dsram_pkg::LANE_W +: dsram_pkg::LANE_W];
      end
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign bus.rdata            = state_reg.q;
  assign bus.rdata_oe_n       = state_reg.q_oe_n;
  assign bus.echo_strobe_true = state_reg.echo_t;
  assign bus.echo_strobe_inv  = state_reg.echo_i;
  assign o_dll_locked         = state_reg.locked;
  assign o_impedance_cal_done = state_reg.cal_done;
  assign o_drive_impedance    = state_reg.drive_imp;

endmodule

/* File: dsram_monitor.sv */
`timescale 1ns/1ps
module dsram_monitor (
  input wire logic                         i_core_clk,
  input wire logic                         i_reset_n,
  input wire logic                         strobe_true,
  input wire logic                         strobe_inv,
  input wire logic                         out_ref_true,
  input wire logic                         out_ref_inv,
  input wire logic [dsram_pkg::ADDR_W-1:0] addr,
  input wire logic                         read_sel,
  input wire logic                         bank_select_n,
  input wire logic [dsram_pkg::DATA_W-1:0] wdata,
  input wire logic [dsram_pkg::LANES-1:0]  byte_lane_mask_n,
  input wire logic [dsram_pkg::DATA_W-1:0] rdata,
  input wire logic                         rdata_oe_n,
  input wire logic                         echo_strobe_true,
  input wire logic                         echo_strobe_inv
);
  logic [3:0] rd_age_reg;

  // ************************************************************
  // cycles since the last read slot; saturates
  // ************************************************************
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      rd_age_reg <= 4'hF;
    else if ($rose(strobe_true) && read_sel && !bank_select_n)
      rd_age_reg <= 4'h0;
    else if (rd_age_reg != 4'hF)
      rd_age_reg <= rd_age_reg + 4'h1;
  end

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_rd;
    $rose(strobe_true) && read_sel && !bank_select_n;
  endsequence
  property p_rd_lat; s_rd |-> ##[3:5] !rdata_oe_n; endproperty
  property p_echo_pair; echo_strobe_true != echo_strobe_inv; endproperty
  property p_strobe_pair; strobe_inv == !strobe_true; endproperty
  property p_toggle; $rose(strobe_true) |=> $fell(strobe_true); endproperty
  property p_ref_hold; out_ref_true && out_ref_inv |=> out_ref_true && out_ref_inv; endproperty
  // bank deselected slots never capture, so the port must stay released
  property p_release; !rdata_oe_n |-> rd_age_reg <= 4'h6; endproperty
  property p_first_word; $fell(rdata_oe_n) |-> $rose(echo_strobe_inv); endproperty
  property p_burst; $fell(rdata_oe_n) |=> !rdata_oe_n; endproperty

  a_rd_lat: assert property (p_rd_lat) else $error("read data late");
  a_echo_pair: assert property (p_echo_pair) else $error("echo pair not complementary");
  a_strobe_pair: assert property (p_strobe_pair) else $error("strobe pair broken");
  a_toggle: assert property (p_toggle) else $error("strobe cycle stretched");
  a_ref_hold: assert property (p_ref_hold) else $error("tied references moved");
  a_release: assert property (p_release) else $error("read port driven idle");
  a_first_word: assert property (p_first_word) else $error("first word unmarked");
  a_burst: assert property (p_burst) else $error("burst cut short");

  c_read: cover property (s_rd);
  c_write: cover property ($rose(strobe_true) && !read_sel && !bank_select_n);
  c_b2b: cover property (!rdata_oe_n [*4]);
endmodule

/* File: ddr_separate_io_burst2_sram_tb.sv */
`timescale 1ns/1ps
module ddr_separate_io_burst2_sram_tb;
  logic        i_core_clk, i_reset_n, req_valid, req_write, req_ready, link_ready;
  logic        rd_valid, dll_locked, cal_done;
  logic        strobe_stop, single;
  logic [19:0] req_addr;
  logic [17:0] wd0, wd1, rd0, rd1, e0, e1;
  logic [1:0]  m0, m1;
  logic [7:0]  drive_imp;
  logic [17:0] mem [bit [20:0]] = '{default: 'x};
  logic [35:0] exp_q [$];
  int          n_fail, cmp_count, i, ph;
  integer      seed = 32'hcdd0ea9d;

  dsram_if bus ();
  dsram_ctl u_dsram_ctl (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
    .i_strobe_stop(strobe_stop), .i_single_strobe(single), .i_req_valid(req_valid),
    .i_req_write(req_write), .i_req_addr(req_addr), .i_req_wdata0(wd0),
    .i_req_wdata1(wd1), .i_req_mask0_n(m0), .i_req_mask1_n(m1), .o_req_ready(req_ready),
    .o_link_ready(link_ready), .o_rd_valid(rd_valid), .o_rd_data0(rd0),
    .o_rd_data1(rd1), .bus(bus));
  dsram_dev u_dsram_dev (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
    .i_impedance_resistor(10'h12C), .o_dll_locked(dll_locked),
    .o_impedance_cal_done(cal_done), .o_drive_impedance(drive_imp), .bus(bus));
  dsram_monitor u_dsram_monitor (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
    .strobe_true(bus.strobe_true), .strobe_inv(bus.strobe_inv),
    .out_ref_true(bus.out_ref_true), .out_ref_inv(bus.out_ref_inv), .addr(bus.addr),
    .read_sel(bus.read_sel), .bank_select_n(bus.bank_select_n), .wdata(bus.wdata),
    .byte_lane_mask_n(bus.byte_lane_mask_n), .rdata(bus.rdata),
    .rdata_oe_n(bus.rdata_oe_n), .echo_strobe_true(bus.echo_strobe_true),
    .echo_strobe_inv(bus.echo_strobe_inv));

  function automatic logic [17:0] merge(logic [17:0] old_w, logic [17:0] new_w,
                                        logic [1:0] m_n);
    merge = old_w;
    if (!m_n[0]) merge[8:0] = new_w[8:0];
    if (!m_n[1]) merge[17:9] = new_w[17:9];
  endfunction

  task final_report;
  begin
    if (n_fail == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask

  // ************************************************************
  // one request, held until taken; valid left high for chaining
  // ************************************************************
  task send(input logic wr, input logic [19:0] a, input logic full);
  begin
    req_write = wr;
    req_addr  = a;
    wd0 = 18'($random(seed));
    wd1 = 18'($random(seed));
    m0  = full ? 2'h0 : 2'($random(seed));
    m1  = full ? 2'h0 : 2'($random(seed));
    if (wr)
    begin
      mem[{a, 1'b0}] = merge(mem[{a, 1'b0}], wd0, m0);
      mem[{a, 1'b1}] = merge(mem[{a, 1'b1}], wd1, m1);
    end
    else
      exp_q.push_back({mem[{a, 1'b0}], mem[{a, 1'b1}]});
    req_valid = 1'b1;
    do @(posedge i_core_clk); while (req_ready !== 1'b1);
    #1;
  end
  endtask

  initial
  begin
    i_core_clk = 1'b0;
    forever #2 i_core_clk = ~i_core_clk;
  end

  initial
  begin
    #40000;
    n_fail++;
    final_report;
  end

  always @(negedge i_core_clk)
  begin
    if (rd_valid === 1'b1)
    begin
      {e0, e1} = exp_q.pop_front();
      cmp_count += 2;
      if (rd0 !== e0)
      begin
        $display("CHECK FAILED rd_data0 exp %h got %h", e0, rd0);
        n_fail++;
      end
      if (rd1 !== e1)
      begin
        $display("CHECK FAILED rd_data1 exp %h got %h", e1, rd1);
        n_fail++;
      end
    end
  end

  initial
  begin
    {req_valid, req_write, req_addr, wd0, wd1, m0, m1, strobe_stop} = '0;
    for (ph = 0; ph < 2; ph++)
    begin
      // second pass: mid-run reset into the separate reference mode
      i_reset_n   = 1'b0;
      single      = (ph == 0);
      strobe_stop = 1'b0;
      repeat (12) @(posedge i_core_clk);
      #1 i_reset_n = 1'b1;
      cmp_count++;
      if (drive_imp !== 8'h32)
      begin
        $display("CHECK FAILED drive_imp exp %h got %h", 8'h32, drive_imp);
        n_fail++;
      end
      for (i = 0; i < 3000 && link_ready !== 1'b1; i++) @(posedge i_core_clk);
      #1;
      for (i = 0; i < 16; i++) send(1'b1, 20'(i), 1'b1);
      send(1'b1, 20'hFFFFF, 1'b1);
      send(1'b0, 20'hFFFFF, 1'b0);
      send(1'b1, 20'h00003, 1'b0);
      send(1'b0, 20'h00003, 1'b0);
      for (i = 0; i < 300; i++)
        send(1'($random(seed)), 20'($random(seed)) & 20'h0000F, 1'b0);
      req_valid = 1'b0;
      repeat (40) @(posedge i_core_clk);
      cmp_count++;
      if ({dll_locked, cal_done, drive_imp} !== {2'h3, 8'h3C})
      begin
        $display("CHECK FAILED lock_cal_imp exp %h got %h", {2'h3, 8'h3C},
                 {dll_locked, cal_done, drive_imp});
        n_fail++;
      end
      if (exp_q.size() != 0)
      begin
        $display("CHECK FAILED pending_reads exp %0d got %0d", 0, exp_q.size());
        n_fail++;
      end
      // strobes held: lock and link must both drop
      #1 strobe_stop = 1'b1;
      repeat (20) @(posedge i_core_clk);
      #1;
      cmp_count++;
      if ({dll_locked, link_ready} !== 2'h0)
      begin
        $display("CHECK FAILED lock_link exp %h got %h", 2'h0, {dll_locked, link_ready});
        n_fail++;
      end
    end
    final_report;
  end
endmodule
